// file: pkg/sdbcg_pkg.sv
// constants, commands, register map and state layout of the sdram burst and clock-gate core
package sdbcg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // array geometry: four banks of 8M byte-wide words
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 8;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int RD_PIPE = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // mode word fields, taken from the address pins on a mode load
  localparam int MODE_W = 7;
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RST = 7'h20;

  ////////////////////////////////////////////////////////////////////////////////
  // commands coded as {row strobe, column strobe, write enable}, all active low
  typedef enum logic [2:0] {
    CMD_MODE_LOAD = 3'b000,
    CMD_REFRESH = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ROW_OPEN = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ = 3'b101,
    CMD_STOP = 3'b110,
    CMD_NOP = 3'b111
  } sdbcg_cmd_e;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_PWRDN = 2'b01,
    MD_SELFREF = 2'b10
  } sdbcg_mode_e;

  ////////////////////////////////////////////////////////////////////////////////
  // register map on the bus, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_REFCNT = 8'h0c;
  localparam logic CTRL_RST = 1'b1;
  localparam int REFCNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic bankSelectHigh;
    logic bankSelectLow;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq;
  } sdbcg_pins_s;

  typedef struct packed {
    logic valid;
    logic [DQ_W-1:0] data;
  } sdbcg_rdword_s;

  typedef struct packed {
    sdbcg_pins_s sync1;
    sdbcg_pins_s sync2;
    logic ckeLast;
    sdbcg_mode_e mode;
    logic [MODE_W-1:0] modeWord;
    logic [BANKS-1:0] bankOpen;
    logic [BANKS-1:0][ROW_W-1:0] openRow;
    logic burstAct;
    logic burstWr;
    logic burstAp;
    logic [BANK_W-1:0] burstBank;
    logic [COL_W-1:0] startCol;
    logic [COL_W-1:0] burstIdx;
    sdbcg_rdword_s [RD_PIPE-1:0] rdPipe;
    logic [DQ_W-1:0] dqOut;
    logic dqOe;
    logic cmdEnable;
    logic [REFCNT_W-1:0] refCnt;
    logic ahbPend;
    logic ahbWrite;
    logic [7:0] ahbAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sdbcg_state_s;

endpackage

// file: hdl/sdbcg_core.sv
// sdram device core: command decode, bursts, read latency, clock gating, bus registers
//
// Summary of operation
// - every pin is sampled on the rising sys_clk edge, never acted on otherwise
// - four independent banks of 8M bytes; each access hits one bank only
// - bursts begin at the given column and run the programmed length and order
// - burst length 1, 2, 4, 8 or full page; a stop command cuts it short
// - auto precharge closes the row by itself when a burst of length 1, 2, 4 or 8 runs to its end; full-page bursts ignore it
// - read latency two or three cycles from read command to first data
// - burst order sequential or interleaved, applied to every read and write burst except full page, which is always sequential
// - clock gate low freezes internal clock, outputs and burst address next cycle
// - clock gate low with all banks idle enters power-down or self refresh
// - in low-power modes the gate input is still sampled on the rising edge and exits without a command
// - low-power modes ignore every other sdram pin until exit; the bus registers stay live
// - bank select 00,01,10,11 picks banks one to four; high line is upper bit
`timescale 1ns/10ps
module sdbcg_core #(
  parameter int MEM_BITS = sdbcg_pkg::MEM_AW
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // sdram pins from the controller
  input wire sdbcg_pkg::sdbcg_pins_s pinsIn,
  // sdram data output
  output logic [sdbcg_pkg::DQ_W-1:0] dqOut,
  output logic dqOe,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import sdbcg_pkg::*;

  sdbcg_state_s st;
  sdbcg_state_s st_nxt;
  logic [DQ_W-1:0] mem [0:(1<<MEM_BITS)-1];

  ////////////////////////////////////////////////////////////////////////////////
  // burst helpers
  function automatic logic [10:0] burstLen(input logic [2:0] bl);
    case (bl)
      BL_2: burstLen = 11'h002;
      BL_4: burstLen = 11'h004;
      BL_8: burstLen = 11'h008;
      BL_PAGE: burstLen = 11'(1 << COL_W);
      default: burstLen = 11'h001;
    endcase
  endfunction

  // wraps inside the aligned block of the burst length; page bursts are always sequential
  function automatic logic [COL_W-1:0] burstCol(input logic [COL_W-1:0] start,
                                                input logic [COL_W-1:0] idx,
                                                input logic [2:0] bl,
                                                input logic il);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] low;
    mask = COL_W'(burstLen(bl) - 11'h001);
    if (il && bl != BL_PAGE) begin
      low = start ^ idx;
    end else begin
      low = start + idx;
    end
    burstCol = (start & ~mask) | (low & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the synchronised pins
  sdbcg_pins_s p;
  sdbcg_cmd_e cmd;
  logic [BANK_W-1:0] ba;
  logic [2:0] bl;
  logic il;
  logic [2:0] cl;
  logic allIdle;
  logic run;
  logic cmdOk;
  logic newAcc;
  logic accValid;
  logic accWr;
  logic accAp;
  logic accLast;
  logic [BANK_W-1:0] accBank;
  logic [COL_W-1:0] accStart;
  logic [COL_W-1:0] accIdx;
  logic [COL_W-1:0] accCol;
  logic [MEM_BITS-1:0] memAddr;
  logic memWe;
  logic addrPhase;
  logic mapped;
  sdbcg_rdword_s outSel;

  always_comb begin
    p = st.sync2;
    cmd = sdbcg_cmd_e'({p.rasN, p.casN, p.weN});
    ba = {p.bankSelectHigh, p.bankSelectLow};
    bl = st.modeWord[BL_LSB +: 3];
    il = st.modeWord[BT_BIT];
    cl = st.modeWord[CL_LSB +: 3];
    allIdle = (st.bankOpen == '0) && !st.burstAct;
    // internal clock runs only when the gate was high on the previous edge
    run = (st.mode == MD_NORMAL) && st.ckeLast;
    cmdOk = run && !p.csN && st.cmdEnable;
    // a read or write only to a bank whose row is open
    newAcc = cmdOk && (cmd == CMD_READ || cmd == CMD_WRITE) && st.bankOpen[ba];
    accValid = newAcc || (run && st.burstAct && !(cmdOk && cmd == CMD_STOP));
    accBank = newAcc ? ba : st.burstBank;
    accStart = newAcc ? p.addr[COL_W-1:0] : st.startCol;
    accIdx = newAcc ? '0 : st.burstIdx;
    accWr = newAcc ? (cmd == CMD_WRITE) : st.burstWr;
    accAp = newAcc ? (p.addr[AP_BIT] && bl != BL_PAGE) : st.burstAp;
    accLast = (bl != BL_PAGE) && ({1'b0, accIdx} == burstLen(bl) - 11'h001);
    accCol = burstCol(accStart, accIdx, bl, il);
    memAddr = MEM_BITS'({accBank, st.openRow[accBank], accCol});
    memWe = accValid && accWr;
    outSel = (cl == CL_3) ? st.rdPipe[1] : st.rdPipe[0];
    addrPhase = hsel && hready && htrans[1];
    mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array write port; contents are not reset, like the real cells
  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      mem[memAddr] <= p.dq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st;
    // pins pass two flops; the first stage feeds only the second
    st_nxt.sync1 = pinsIn;
    st_nxt.sync2 = st.sync1;

    // clock gate and low-power modes
    unique case (st.mode)
      MD_NORMAL: begin
        st_nxt.ckeLast = p.cke;
        if (st.ckeLast && !p.cke && allIdle &&
            (p.csN || cmd == CMD_NOP || cmd == CMD_REFRESH)) begin
          st_nxt.mode = (!p.csN && cmd == CMD_REFRESH) ? MD_SELFREF : MD_PWRDN;
        end
      end
      MD_PWRDN, MD_SELFREF: begin
        // only the gate is looked at; it ends the mode as soon as it is seen high
        st_nxt.ckeLast = p.cke;
        if (p.cke) begin
          st_nxt.mode = MD_NORMAL;
        end
        st_nxt.dqOe = 1'b0;
      end
      default: st_nxt.mode = MD_NORMAL; // unused code 11 falls back to normal
    endcase

    if (run) begin
      // burst sequencing: suspended cycles skip all of this and hold state
      if (cmdOk && cmd == CMD_STOP) begin
        st_nxt.burstAct = 1'b0;
      end
      if (accValid) begin
        st_nxt.burstAct = !accLast;
        st_nxt.burstBank = accBank;
        st_nxt.startCol = accStart;
        st_nxt.burstIdx = accIdx + 1'b1;
        st_nxt.burstWr = accWr;
        st_nxt.burstAp = accAp;
        if (accLast && accAp) begin
          st_nxt.bankOpen[accBank] = 1'b0;
        end
      end
      // read pipeline and output register
      st_nxt.rdPipe[1] = st.rdPipe[0];
      st_nxt.rdPipe[0].valid = accValid && !accWr;
      st_nxt.rdPipe[0].data = mem[memAddr];
      st_nxt.dqOut = outSel.data;
      st_nxt.dqOe = outSel.valid;

      if (cmdOk) begin
        unique case (cmd)
          CMD_ROW_OPEN: begin
            if (!st.bankOpen[ba]) begin
              st_nxt.bankOpen[ba] = 1'b1;
              st_nxt.openRow[ba] = p.addr[ROW_W-1:0];
            end
          end
          CMD_PRECHARGE: begin
            if (p.addr[AP_BIT]) begin
              st_nxt.bankOpen = '0;
              st_nxt.burstAct = 1'b0;
            end else begin
              st_nxt.bankOpen[ba] = 1'b0;
              if (st_nxt.burstBank == ba) begin
                st_nxt.burstAct = 1'b0;
              end
            end
          end
          CMD_MODE_LOAD: begin
            // a mode change under an open row would corrupt a running burst
            if (allIdle) begin
              st_nxt.modeWord = p.addr[MODE_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // bus data phase; a clear of the count and a refresh in the same cycle leave the count at one
    if (st.ahbPend && st.ahbWrite) begin
      if (st.ahbAddr == REG_CTRL) begin
        st_nxt.cmdEnable = hwdata[0];
      end
      if (st.ahbAddr == REG_REFCNT) begin
        st_nxt.refCnt = '0;
      end
    end
    // auto refreshes counted only with banks idle and the gate held high
    if (cmdOk && cmd == CMD_REFRESH && allIdle && p.cke) begin
      st_nxt.refCnt = st_nxt.refCnt + 1'b1;
    end

    // bus address phase; zero wait states, read data registered for the data phase
    st_nxt.ahbPend = addrPhase;
    st_nxt.ahbWrite = hwrite;
    st_nxt.ahbAddr = mapped ? haddr[7:0] : 8'hff;
    st_nxt.hrdata = 32'h00000000;
    if (addrPhase && !hwrite && mapped) begin
      unique case (haddr[7:0])
        REG_CTRL: st_nxt.hrdata = {31'h00000000, st.cmdEnable};
        REG_STATUS: st_nxt.hrdata = {24'h000000, st.mode == MD_SELFREF,
                                     st.mode == MD_PWRDN,
                                     st.mode == MD_NORMAL && !st.ckeLast,
                                     st.burstAct, st.bankOpen};
        REG_MODE: st_nxt.hrdata = {25'h0000000, st.modeWord};
        REG_REFCNT: st_nxt.hrdata = {16'h0000, st.refCnt};
        default: st_nxt.hrdata = 32'h00000000;
      endcase
    end
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.sync1.csN <= 1'b1;
      st.sync2.csN <= 1'b1;
      st.mode <= MD_NORMAL;
      st.modeWord <= MODE_RST;
      st.cmdEnable <= CTRL_RST;
      st.ahbAddr <= 8'hff;
      st.hreadyout <= 1'b1;
    end else begin
      st <= st_nxt;
    end
  end

  assign dqOut = st.dqOut;
  assign dqOe = st.dqOe;
  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // latency counts running cycles only; a suspended cycle stretches it
  sequence rdCmdSeq;
    newAcc && cmd == CMD_READ;
  endsequence

  sequence cl2Seq;
    (rdCmdSeq and cl != CL_3) ##1 run;
  endsequence

  sequence cl3Seq;
    (rdCmdSeq and cl == CL_3) ##1 run [*2];
  endsequence

  a_read_lat_two: assert property (cl2Seq |=> st.dqOe)
    else $error("read data not out two cycles after read");
  a_read_lat_three: assert property (cl3Seq |=> st.dqOe)
    else $error("read data not out three cycles after read");
  a_suspend_hold: assert property (
    st.mode == MD_NORMAL && !st.ckeLast
    |=> $stable(st.dqOut) && $stable(st.burstIdx) && $stable(st.bankOpen))
    else $error("state moved while clock suspended");
  a_row_open_bank: assert property (
    cmdOk && cmd == CMD_ROW_OPEN && !st.bankOpen[ba]
    |=> st.bankOpen[$past(ba)] && st.openRow[$past(ba)] == $past(p.addr))
    else $error("row open did not reach selected bank");
  a_burst_start: assert property (
    newAcc && burstLen(bl) != 11'h001
    |=> st.burstAct && st.burstIdx == 10'h001
    && st.startCol == $past(p.addr[COL_W-1:0]))
    else $error("burst did not start at given column");
  // a new access in the last cycle restarts the burst, so it is left out here
  a_burst_end: assert property (
    run && st.burstAct && !newAcc && accLast |=> !st.burstAct)
    else $error("burst ran past its length");
  a_stop_cut: assert property (cmdOk && cmd == CMD_STOP |=> !st.burstAct)
    else $error("stop command did not end the burst");
  a_auto_pre: assert property (
    accValid && accLast && accAp |=> !st.bankOpen[$past(accBank)])
    else $error("auto precharge did not close the row");
  a_order_seq: assert property (
    accValid && !il && bl == BL_4
    |-> accCol[1:0] == 2'(accStart[1:0] + accIdx[1:0])
    && accCol[COL_W-1:2] == accStart[COL_W-1:2])
    else $error("sequential column wrong");
  a_order_il: assert property (
    accValid && il && bl == BL_4
    |-> accCol[1:0] == (accStart[1:0] ^ accIdx[1:0])
    && accCol[COL_W-1:2] == accStart[COL_W-1:2])
    else $error("interleaved column wrong");
  // a clear and a refresh in one cycle leave one: the clear applies, then the refresh counts
  a_refresh_count: assert property (
    cmdOk && cmd == CMD_REFRESH && allIdle && p.cke
    |=> st.refCnt == $past(st.refCnt) + 16'h0001 || st.refCnt == 16'h0001)
    else $error("auto refresh not counted");
  a_pd_entry: assert property (
    st.mode == MD_NORMAL && st.ckeLast && !p.cke && allIdle
    && (p.csN || cmd == CMD_NOP) |=> st.mode == MD_PWRDN)
    else $error("power-down not entered");
  a_sr_entry: assert property (
    st.mode == MD_NORMAL && st.ckeLast && !p.cke && allIdle
    && !p.csN && cmd == CMD_REFRESH |=> st.mode == MD_SELFREF)
    else $error("self refresh not entered");
  a_pd_exit: assert property (st.mode != MD_NORMAL && p.cke |=> st.mode == MD_NORMAL)
    else $error("low-power mode not left on gate high");
  a_pd_ignore: assert property (
    st.mode != MD_NORMAL |=> $stable(st.bankOpen) && $stable(st.modeWord) && !st.dqOe)
    else $error("input acted on in low-power mode");

endmodule

// file: testbench/sdbcg_ctrl_model.sv
// controller-side model driving the sdram pins of the core
`timescale 1ns/10ps
module sdbcg_ctrl_model (
  // clock
  input wire logic sys_clk,
  // pins towards the device
  output sdbcg_pkg::sdbcg_pins_s pinsOut
);
  import sdbcg_pkg::*;

  sdbcg_pins_s pins = {1'b1, 1'b0, 3'b111, 2'h0, 13'h0000, 8'h00};
  logic gate = 1'b1;

  ////////////////////////////////////////////////////////////
  // clock gate kept apart so the bench can freeze a burst mid-way
  always_comb begin
    pinsOut = pins;
    pinsOut.cke = gate;
  end

  // one command cycle, changed just after a rising edge
  task automatic drive(input sdbcg_cmd_e c, input logic [1:0] b, input logic [12:0] a,
                       input logic [7:0] d);
    @(posedge sys_clk);
    pins <= {1'b1, 1'b0, c, b[1], b[0], a, d};
  endtask

  // back to nop; a released data line shows the inverse, not a stale copy
  task automatic rest();
    @(posedge sys_clk);
    pins <= {1'b1, 1'b0, CMD_NOP, 2'h0, 13'h0000, ~pins.dq};
  endtask

  // single command followed by release
  task automatic send(input sdbcg_cmd_e c, input logic [1:0] b, input logic [12:0] a);
    drive(c, b, a, ~pins.dq);
    rest();
  endtask
endmodule

// file: testbench/sdram_burst_and_clock_gate_core_tb.sv
// self-checking bench: bursts, latency, order, clock gate and low-power modes
`timescale 1ns/10ps
module sdram_burst_and_clock_gate_core_tb;
  import sdbcg_pkg::*;

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  sdbcg_pins_s pinsIn;
  logic [7:0] dqOut;
  logic dqOe, hsel, hwrite, hreadyout, hresp, rdyN;
  logic [31:0] haddr, hwdata, hrdata, rdN, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int bad_count = 0;
  int checks = 0;
  int i, n;
  logic [2:0] blc [6] = '{BL_1, BL_2, BL_4, BL_4, BL_8, BL_8};
  int lens [6] = '{1, 2, 4, 4, 8, 8};
  logic ilv [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  logic [2:0] clv [6] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3};
  logic [9:0] cols [6] = '{10'h3, 10'h3, 10'h5, 10'h5, 10'h3, 10'h6};

  ////////////////////////////////////////////////////////////
  // clock and bus-side sampling at the falling edge, free of edge races
  always #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    rdyN = hreadyout;
    rdN = hrdata;
  end

  sdbcg_ctrl_model i_ctrl (.sys_clk(sys_clk), .pinsOut(pinsIn));
  sdbcg_core #(.MEM_BITS(12)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .pinsIn(pinsIn), .dqOut(dqOut), .dqOe(dqOe),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // bounded wait for hready at a rising edge
  task automatic waitrdy();
    int w;
    w = 0;
    do begin
      @(posedge sys_clk);
      w++;
    end while (rdyN !== 1'b1 && w < 20);
    if (rdyN !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask

  // one single-word ahb-lite transfer
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    waitrdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitrdy();
    rd = rdN;
  endtask

  // read after the pin synchronisers have settled
  task automatic rdreg(input logic [31:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, a, 32'h0, r);
    chk(nm, r, exp);
    chk("bus response", hresp, 32'h0);
  endtask

  // all banks idle, load the mode word, reopen bank three
  task automatic setmode(input logic [2:0] bl, input logic il, input logic [2:0] cl);
    i_ctrl.send(CMD_PRECHARGE, 2'h0, 13'h0400);
    i_ctrl.send(CMD_MODE_LOAD, 2'h0, {6'h00, cl, il, bl});
    i_ctrl.send(CMD_ROW_OPEN, 2'h2, 13'h0000);
    rdreg(REG_MODE, {25'h0, cl, il, bl}, "mode word");
  endtask

  // read burst; column k of row zero holds 0x40+k; repeats from a freeze are skipped
  task automatic burst_rd(input logic [9:0] col, input int len, input logic il,
                          input logic [2:0] cl, input logic susp, input logic ap);
    int k, got, hi;
    logic [7:0] prev, c;
    got = 0;
    hi = 0;
    prev = 8'h00;
    i_ctrl.send(CMD_READ, 2'h2, {2'h0, ap, col});
    for (k = 1; k < 40; k++) begin
      @(posedge sys_clk);
      if (susp && k == 4) i_ctrl.gate <= 1'b0;
      if (susp && k == 6) i_ctrl.gate <= 1'b1;
      @(negedge sys_clk);
      if (dqOe === 1'b1) begin
        if (hi == 0 && !susp) chk("latency", k, cl + 1);
        hi++;
        if (dqOut !== prev) begin
          c = il ? col ^ got : (col & ~(len - 1)) | ((col + got) & (len - 1));
          chk("burst data", dqOut, 8'h40 + c);
          got++;
          prev = dqOut;
        end
      end else if (hi > 0) break;
    end
    if (k >= 40) begin
      bad_count++;
      conclude();
    end
    chk("burst words", got, len);
    chk("burst cycles", susp ? hi > len : hi, susp ? 1 : len);
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdreg(REG_MODE, 32'h20, "mode reset");
    rdreg(32'h10, 32'h0, "unmapped");
    ahb(1'b1, REG_CTRL, 32'h0, v);
    i_ctrl.send(CMD_ROW_OPEN, 2'h1, 13'h0000);
    rdreg(REG_STATUS, 32'h0, "commands off");
    ahb(1'b1, REG_CTRL, 32'h1, v);
    i_ctrl.send(CMD_REFRESH, 2'h0, 13'h0000);
    i_ctrl.send(CMD_REFRESH, 2'h0, 13'h0000);
    rdreg(REG_REFCNT, 32'h2, "refresh count");
    ahb(1'b1, REG_REFCNT, 32'h0, v);
    for (i = 0; i < 4; i++) begin
      i_ctrl.send(CMD_ROW_OPEN, i[1:0], 13'h0000);
      rdreg(REG_STATUS, (32'h1 << (i + 1)) - 1, "bank map");
    end
    i_ctrl.send(CMD_REFRESH, 2'h0, 13'h0000);
    rdreg(REG_REFCNT, 32'h0, "refresh refused");
    setmode(BL_8, 1'b0, 3'h2);
    i_ctrl.drive(CMD_WRITE, 2'h2, 13'h0000, 8'h40);
    for (i = 1; i < 8; i++) i_ctrl.drive(CMD_NOP, 2'h0, 13'h0000, 8'h40 + i[7:0]);
    i_ctrl.rest();
    for (i = 0; i < 6; i++) begin
      setmode(blc[i], ilv[i], clv[i]);
      burst_rd(cols[i], lens[i], ilv[i], clv[i], 1'b0, 1'b0);
    end
    setmode(BL_8, 1'b0, 3'h2);
    burst_rd(10'h2, 8, 1'b0, 3'h2, 1'b1, 1'b0);
    burst_rd(10'h0, 8, 1'b0, 3'h2, 1'b0, 1'b1);
    rdreg(REG_STATUS, 32'h0, "auto precharge");
    setmode(BL_PAGE, 1'b0, 3'h2);
    i_ctrl.send(CMD_READ, 2'h2, 13'h0000);
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("page run", dqOe, 1'b1);
    i_ctrl.send(CMD_STOP, 2'h0, 13'h0000);
    for (n = 0; n < 8 && dqOe !== 1'b0; n++) @(negedge sys_clk);
    chk("stopped", dqOe, 1'b0);
    i_ctrl.send(CMD_PRECHARGE, 2'h0, 13'h0400);
    @(posedge sys_clk);
    i_ctrl.gate <= 1'b0;
    rdreg(REG_STATUS, 32'h40, "power-down");
    i_ctrl.send(CMD_ROW_OPEN, 2'h1, 13'h0000);
    @(posedge sys_clk);
    i_ctrl.gate <= 1'b1;
    rdreg(REG_STATUS, 32'h0, "power-down exit");
    i_ctrl.drive(CMD_REFRESH, 2'h0, 13'h0000, 8'h00);
    i_ctrl.gate <= 1'b0;
    i_ctrl.rest();
    rdreg(REG_STATUS, 32'h80, "self refresh");
    rdreg(REG_REFCNT, 32'h0, "self refresh count");
    @(posedge sys_clk);
    i_ctrl.gate <= 1'b1;
    rdreg(REG_STATUS, 32'h0, "self refresh exit");
    conclude();
  end
endmodule
